// ### logic/lps_pkg.sv
// Constants for the light pen and display status port block.
// Assumes a PC-style 10-bit I/O address bus and 8-bit data.
package lps_pkg;
  localparam logic [3:0] LPS_OFF_STATUS = 4'ha;
  localparam logic [3:0] LPS_OFF_CLEAR  = 4'hb;
  localparam logic [3:0] LPS_OFF_SET    = 4'hc;
  localparam logic [9:0] LPS_BASE_MONO  = 10'h3b0;
  localparam logic [9:0] LPS_BASE_COLOR = 10'h3d0;
  localparam logic [3:0] LPS_NIB_MONO_0  = 4'h2;
  localparam logic [3:0] LPS_NIB_MONO_1  = 4'h3;
  localparam logic [3:0] LPS_NIB_MONO_2  = 4'ha;
  localparam logic [3:0] LPS_NIB_MONO_3  = 4'h8;
  localparam logic [3:0] LPS_NIB_COLOR_0 = 4'h4;
  localparam logic [3:0] LPS_NIB_COLOR_1 = 4'h5;
  localparam logic [3:0] LPS_NIB_COLOR_2 = 4'hc;
  localparam logic [3:0] LPS_NIB_COLOR_3 = 4'hd;
  localparam int LPS_BIT_RETRACE = 0;
  localparam int LPS_BIT_LATCH   = 1;
  localparam int LPS_BIT_SWITCH  = 2;
  localparam int LPS_BIT_VSYNC   = 3;
  localparam int LPS_CNT_LSB     = 4;
  localparam logic [3:0] LPS_STRAP_DEFAULT = 4'hf;
  localparam logic       LPS_LATCH_RESET   = 1'b0;
  localparam logic [3:0] LPS_COUNT_RESET   = 4'h0;
  localparam logic [7:0] LPS_RDATA_RESET   = 8'h00;
endpackage

// ### logic/lps_status_ports.sv
// Host I/O ports for display status, light pen latch and pixel count.
// Assumes host strobes are one-cycle pulses synchronous to clk.
`timescale 1ns/1ps
module lps_status_ports
  import lps_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       srst,
  input  wire logic [9:0] io_addr,
  input  wire logic       io_rd,
  input  wire logic       io_wr,
  input  wire logic [7:0] io_wdata,
  output logic      [7:0] io_rdata,
  output logic            io_rdata_oe,
  input  wire logic [3:0] base_strap,
  input  wire logic       color_mode,
  input  wire logic       hretrace,
  input  wire logic       vretrace,
  input  wire logic       vsync,
  input  wire logic       video_on,
  input  wire logic       pixel_tick,
  input  wire logic       pen_trigger,
  input  wire logic       pen_switch_open,
  output logic            pen_latch
);

  // Mono and colour base pair picked by the straps; all ones keeps the default pair
  function automatic logic [9:0] base_of(
    input logic [3:0] s,
    input logic       color
  );
    logic [9:0] b;
    b      = 10'h000;
    b[9:8] = s[3:2];
    unique case (s[1:0])
      2'h0:
      begin
        b[7:4] = color ? LPS_NIB_COLOR_0 : LPS_NIB_MONO_0;
      end
      2'h1:
      begin
        b[7:4] = color ? LPS_NIB_COLOR_1 : LPS_NIB_MONO_1;
      end
      2'h2:
      begin
        b[7:4] = color ? LPS_NIB_COLOR_2 : LPS_NIB_MONO_2;
      end
      2'h3:
      begin
        b[7:4] = color ? LPS_NIB_COLOR_3 : LPS_NIB_MONO_3;
      end
    endcase
    if (s == LPS_STRAP_DEFAULT)
    begin
      b = color ? LPS_BASE_COLOR : LPS_BASE_MONO;
    end
    return b;
  endfunction

  // Offset decode against the base for the current emulation
  function automatic logic hit(
    input logic [9:0] a,
    input logic [3:0] off,
    input logic [9:0] base
  );
    return (a[9:4] == base[9:4]) && (a[3:0] == off);
  endfunction

  logic [9:0] base_w;
  logic       acc_w;
  logic       latch_q;
  logic       latch_d;
  logic [3:0] pix_q;
  logic [3:0] pix_d;
  logic [3:0] cap_q;
  logic [3:0] cap_d;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  logic       oe_q;
  logic       oe_d;
  logic [7:0] status_w;
  logic       sts_hit_w;
  logic       clr_hit_w;
  logic       set_hit_w;
  logic       pen_hit_w;

  // Write data is never stored; every port is read-only or strobe-only
  assign base_w    = base_of(base_strap, color_mode);
  assign acc_w     = io_rd | io_wr;
  assign pen_hit_w = pen_trigger & ~latch_q;

  // Status byte as seen in the cycle of the read strobe
  always_comb
  begin
    status_w = 8'h00;
    if (color_mode)
    begin
      status_w[LPS_BIT_RETRACE] = hretrace | vretrace;
      status_w[LPS_BIT_VSYNC]   = vsync;
    end
    else
    begin
      status_w[LPS_BIT_RETRACE] = hretrace;
      status_w[LPS_BIT_VSYNC]   = video_on;
    end
    status_w[LPS_BIT_LATCH]  = latch_q;
    status_w[LPS_BIT_SWITCH] = pen_switch_open;
    status_w[7:LPS_CNT_LSB]  = cap_q;
  end

  // Port decode; offsets 13 to 15 and other addresses match nothing
  always_comb
  begin
    sts_hit_w = 1'b0;
    clr_hit_w = 1'b0;
    set_hit_w = 1'b0;
    if (acc_w)
    begin
      sts_hit_w = io_rd && hit(io_addr, LPS_OFF_STATUS, base_w);
      clr_hit_w = hit(io_addr, LPS_OFF_CLEAR, base_w);
      set_hit_w = hit(io_addr, LPS_OFF_SET, base_w);
    end
  end

  // Pixel counter, wraps every sixteen pixels
  always_comb
  begin
    pix_d = pix_q;
    if (pixel_tick)
    begin
      pix_d = pix_q + 4'h1;
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      pix_q <= LPS_COUNT_RESET;
    end
    else
    begin
      pix_q <= pix_d;
    end
  end

  // Pen latch; set access and pen hit win over a clear in the same cycle
  always_comb
  begin
    latch_d = latch_q;
    if (clr_hit_w)
    begin
      latch_d = 1'b0;
    end
    if (set_hit_w)
    begin
      latch_d = 1'b1;
    end
    if (pen_hit_w)
    begin
      latch_d = 1'b1;
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      latch_q <= LPS_LATCH_RESET;
    end
    else
    begin
      latch_q <= latch_d;
    end
  end

  // Count captured only on a pen hit, so a set access leaves it alone
  always_comb
  begin
    cap_d = cap_q;
    if (pen_hit_w)
    begin
      cap_d = pix_q;
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      cap_q <= LPS_COUNT_RESET;
    end
    else
    begin
      cap_q <= cap_d;
    end
  end

  // Read data, zero whenever no status read is answered
  always_comb
  begin
    rdata_d = LPS_RDATA_RESET;
    if (sts_hit_w)
    begin
      rdata_d = status_w;
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      rdata_q <= LPS_RDATA_RESET;
    end
    else
    begin
      rdata_q <= rdata_d;
    end
  end

  // Answer flag; writes to status and unused offsets never raise it
  always_comb
  begin
    oe_d = 1'b0;
    if (sts_hit_w)
    begin
      oe_d = 1'b1;
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      oe_q <= 1'b0;
    end
    else
    begin
      oe_q <= oe_d;
    end
  end

  assign io_rdata    = rdata_q;
  assign io_rdata_oe = oe_q;
  assign pen_latch   = latch_q;

endmodule

// ### verif/lps_chk.sv
// Assertions on the status port block
// Sees only the top ports; base pair follows the straps
`timescale 1ns/1ps
module lps_chk (
  input wire logic       clk,
  input wire logic       srst,
  input wire logic [9:0] io_addr,
  input wire logic       io_rd,
  input wire logic       io_wr,
  input wire logic [7:0] io_rdata,
  input wire logic       io_rdata_oe,
  input wire logic [3:0] base_strap,
  input wire logic       color_mode,
  input wire logic       hretrace,
  input wire logic       vretrace,
  input wire logic       vsync,
  input wire logic       video_on,
  input wire logic       pen_trigger,
  input wire logic       pen_switch_open,
  input wire logic       pen_latch
);
  wire [3:0] mn = base_strap[1] ? (base_strap[0] ? 4'h8 : 4'ha) : (base_strap[0] ? 4'h3 : 4'h2);
  wire [3:0] cn = base_strap[1] ? (base_strap[0] ? 4'hd : 4'hc) : (base_strap[0] ? 4'h5 : 4'h4);
  wire [9:0] b = base_strap == 4'hf ? (color_mode ? 10'h3d0 : 10'h3b0) :
    {base_strap[3:2], color_mode ? cn : mn, 4'h0};
  wire ac = io_rd || io_wr;
  wire st = io_rd && io_addr == b + 10'ha;
  wire cl = ac && io_addr == b + 10'hb;
  wire se = ac && io_addr == b + 10'hc || pen_trigger;
  wire r0 = color_mode ? hretrace || vretrace : hretrace;
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  a_rd_ans: assert property (st |=> io_rdata_oe) else $error("no answer");
  a_no_ans: assert property (!st |=> !io_rdata_oe) else $error("stray");
  a_pen_set: assert property (se |=> pen_latch) else $error("not set");
  a_pen_clr: assert property (cl && !se |=> !pen_latch) else $error("not clear");
  a_pen_hold: assert property (!cl && !se |=> $stable(pen_latch)) else $error("moved");
  a_bit_ret: assert property (io_rdata_oe |-> io_rdata[0] == $past(r0)) else $error("bit 0");
  a_bit_pen: assert property (io_rdata_oe |-> io_rdata[2:1] ==
    {$past(pen_switch_open), $past(pen_latch)}) else $error("bits 2:1");
  a_bit_mode: assert property (io_rdata_oe |-> io_rdata[3] == $past(color_mode ? vsync : video_on))
    else $error("bit 3");
  a_rst_pen: assert property (disable iff (1'b0) srst |=> !pen_latch && !io_rdata_oe)
    else $error("reset");
  cover property (st);
  cover property (cl);
  cover property (se);
  cover property (st && pen_latch);
endmodule
bind lps_status_ports lps_chk u_chk (.*);

// ### verif/lps_host.sv
// Host processor model on the I/O bus
// Assumes one access per call
`timescale 1ns/1ps
module lps_host (
  input  wire logic       clk,
  output logic      [9:0] io_addr,
  output logic            io_rd,
  output logic            io_wr,
  output logic      [7:0] io_wdata
);
  initial {io_addr, io_rd, io_wr, io_wdata} = '0;
  // One-cycle strobe, then strobes dropped and address and data inverted
  task acc(input logic [9:0] a, input logic r);
    @(negedge clk);
    {io_addr, io_rd, io_wr} = {a, r, !r};
    @(negedge clk);
    {io_addr, io_rd, io_wr, io_wdata} = {~a, 2'h0, ~io_wdata};
  endtask
endmodule

// ### verif/tb.sv
// Bench for the status port block
// Starts on default straps, later switches to all-zero straps
`timescale 1ns/1ps
module tb;
  import lps_pkg::*;
  logic clk = 0, srst = 1, cm = 1, hr = 0, vr = 1, vs = 1, vo = 0, pt = 0, tr = 0, so = 1;
  logic [9:0] a;
  logic [3:0] bs = LPS_STRAP_DEFAULT;
  logic rd, wr, oe, pl;
  logic [7:0] wd, q;
  int mismatches, comparisons;
  always #20 clk = ~clk;
  lps_host h (.clk(clk), .io_addr(a), .io_rd(rd), .io_wr(wr), .io_wdata(wd));
  lps_status_ports uut (.clk(clk), .srst(srst), .io_addr(a), .io_rd(rd), .io_wr(wr), .io_wdata(wd),
    .io_rdata(q), .io_rdata_oe(oe), .base_strap(bs), .color_mode(cm), .hretrace(hr),
    .vretrace(vr), .vsync(vs), .video_on(vo), .pixel_tick(pt), .pen_trigger(tr),
    .pen_switch_open(so), .pen_latch(pl));
  task chk(string n, logic [7:0] s, logic [7:0] e);
    comparisons++;
    if (s !== e)
    begin
      mismatches++;
      $display("unexpected %s exp %h got %h", n, e, s);
    end
  endtask
  task st(logic [9:0] b, logic [7:0] e);
    h.acc(b + 10'ha, 1);
    chk("status", oe === 1'b1 ? q : ~e, e);
  endtask
  task finish_test;
    $display("mismatches %0d comparisons %0d", mismatches, comparisons);
    if (mismatches == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial
  begin
    repeat (6) @(negedge clk);
    srst = 0;
    chk("latch", pl, 8'h00);
    st(10'h3d0, 8'h0d);
    h.acc(10'h3dc, 0);
    st(10'h3d0, 8'h0f);
    h.acc(10'h3db, 1);
    chk("latch", pl, 8'h00);
    repeat (5)
    begin
      pt = 1;
      @(negedge clk) pt = 0;
      @(negedge clk);
    end
    tr = 1;
    @(negedge clk) tr = 0;
    so = 0;
    st(10'h3d0, 8'h5b);
    pt = 1;
    @(negedge clk) tr = 1;
    pt = 0;
    @(negedge clk) tr = 0;
    {cm, vo, vs} = 3'h2;
    st(10'h3b0, 8'h5a);
    h.acc(10'h3ba, 0);
    for (int i = 13; i < 16; i++) h.acc(10'h3b0 + i[9:0], i[0]);
    st(10'h3b0, 8'h5a);
    bs = 4'h0;
    st(10'h020, 8'h5a);
    srst = 1;
    @(negedge clk) srst = 0;
    chk("latch", pl, 8'h00);
    finish_test();
  end
endmodule
